// ===== design/poe_select_pkg.sv
package poe_select_pkg;
	// select byte field layout
	localparam int SEL_MSB      = 6;
	localparam int SEL_LSB      = 3;
	localparam int PORT_MSB     = 1;
	localparam int PORT_LSB     = 0;
	localparam logic [7:0] PTR_RESET = 8'h00;
	// register selector codes
	localparam logic [3:0] SEL_SHARED_STATUS = 4'h0;
	localparam logic [3:0] SEL_SHARED_CTRL   = 4'h1;
	localparam logic [3:0] SEL_PORT_CTRL1    = 4'h2;
	localparam logic [3:0] SEL_PORT_CTRL2    = 4'h3;
	localparam logic [3:0] SEL_PORT_STAT1    = 4'h4;
	localparam logic [3:0] SEL_PORT_STAT2    = 4'h5;
	localparam logic [3:0] SEL_RES_LO        = 4'h6;
	localparam logic [3:0] SEL_TEMP_HI       = 4'hD;
	localparam logic [3:0] SEL_UNUSED        = 4'hE;
	localparam logic [3:0] SEL_TEST          = 4'hF;
	// number of converter result bytes per port
	localparam int RESULT_BYTES = 8;
	localparam int NUM_PORTS    = 4;
endpackage

// ===== design/poe_select_decode.sv
`timescale 1ns/1ps
// combinational decode of the latched selector
module poe_select_decode (
	// selection
	input  wire logic [3:0] sel_in,
	input  wire logic [1:0] port_in,
	// decoded strobes
	output logic            shared_ctrl_out,
	output logic            test_out,
	output logic [3:0]      port_ctrl1_out,
	output logic [3:0]      port_ctrl2_out,
	output logic            result_out,
	output logic [2:0]      result_idx_out
);
	wire logic [3:0] port_onehot;
	assign port_onehot = 4'h1 << port_in;
	// shared targets ignore the port field
	assign shared_ctrl_out =
		(sel_in == poe_select_pkg::SEL_SHARED_CTRL);
	assign test_out =
		(sel_in == poe_select_pkg::SEL_TEST);
	// per-port targets reach one port only
	assign port_ctrl1_out = (sel_in == poe_select_pkg::SEL_PORT_CTRL1) ?
		port_onehot : 4'h0;
	assign port_ctrl2_out = (sel_in == poe_select_pkg::SEL_PORT_CTRL2) ?
		port_onehot : 4'h0;
	assign result_out = (sel_in >= poe_select_pkg::SEL_RES_LO) &&
		(sel_in <= poe_select_pkg::SEL_TEMP_HI);
	assign result_idx_out = 3'(sel_in - poe_select_pkg::SEL_RES_LO);
endmodule

// ===== design/poe_port_register_select_map.sv
`timescale 1ns/1ps
// Behaviour
// - selector bits D6..D3 reset to zero and code 0000 reads the shared status.
// - code 0001 reaches the shared control write register.
// - codes 0010 and 0011 reach the two per-port control write registers.
// - codes 0100 and 0101 return the two per-port status bytes.
// - codes 0110..1101 return result pairs, low byte then high byte.
// - code 1110 reaches nothing and code 1111 reaches the shared test register.
// - bits D1..D0 pick port one to four and reset to zero.
// - status bits 7..4 show the fault flags of ports four down to one.
// - status bits 3..2 show the revision and bits 1..0 the chip identity.
// - a fault flag reads one when its port has a fault, else zero.
// - the select byte is latched on the rising edge after its eighth bit.
// - shared writes hit all ports, per-port writes only the chosen port.
module poe_port_register_select_map #(
	parameter logic [1:0] CHIP_REV = 2'h0, // arbitrary value
	parameter logic [1:0] CHIP_ID  = 2'h0  // arbitrary value
) (
	// clock and reset (serial clock rising edge domain)
	input  wire logic       clk_in,
	input  wire logic       rstn_in,
	// byte stream from the serial front end
	input  wire logic       sel_stb_in,
	input  wire logic [7:0] sel_byte_in,
	input  wire logic       wr_stb_in,
	input  wire logic [7:0] wr_data_in,
	// state fed by the port engines
	input  wire logic [3:0] port_fault_in,
	input  wire logic [31:0] port_stat1_in,
	input  wire logic [31:0] port_stat2_in,
	input  wire logic [255:0] result_in,
	// read data and selection
	output logic [7:0]      rd_data_out,
	output logic [7:0]      sel_byte_out,
	// write strobes and data
	output logic            shared_ctrl_we_out,
	output logic            test_we_out,
	output logic [3:0]      port_ctrl1_we_out,
	output logic [3:0]      port_ctrl2_we_out,
	output logic [7:0]      wr_data_out
);
	// widths and field positions
	localparam int BYTE_W    = $bits(sel_byte_in);
	localparam int PORTS     = poe_select_pkg::NUM_PORTS;
	localparam int RES_BYTES = poe_select_pkg::RESULT_BYTES;
	localparam int RES_W     = BYTE_W * RES_BYTES;
	localparam int SEL_HI    = poe_select_pkg::SEL_MSB;
	localparam int SEL_LO    = poe_select_pkg::SEL_LSB;
	localparam int PORT_HI   = poe_select_pkg::PORT_MSB;
	localparam int PORT_LO   = poe_select_pkg::PORT_LSB;
	localparam int SEL_W     = SEL_HI - SEL_LO + 1;
	localparam int PORT_W    = PORT_HI - PORT_LO + 1;

	// refuse geometries that the fixed ports cannot carry
	if (SEL_W != $bits(poe_select_pkg::SEL_TEST)) begin : g_bad_sel
		$error("selector field must be four bits wide");
	end
	if ((1 << PORT_W) != PORTS) begin : g_bad_port
		$error("port field must reach every port exactly");
	end
	if (PORTS * BYTE_W != $bits(port_stat1_in)) begin : g_bad_stat
		$error("status inputs must carry one byte per port");
	end
	if (PORTS * RES_W != $bits(result_in)) begin : g_bad_res
		$error("result input must carry one word per port");
	end
	if (SEL_HI >= BYTE_W || PORT_LO < 0) begin : g_bad_pos
		$error("select fields must lie inside the byte");
	end

	// latched selection
	logic [3:0]             sel_reg;
	logic [1:0]             port_reg;
	// fault flags after two flip-flops
	logic [3:0]             fault_meta_reg;
	logic [3:0]             fault_reg;
	// fields of the incoming select byte
	wire logic [3:0]        sel_next;
	wire logic [1:0]        port_next;
	// decoder results
	wire logic              dec_shared;
	wire logic              dec_test;
	wire logic [3:0]        dec_c1;
	wire logic [3:0]        dec_c2;
	wire logic              dec_res;
	wire logic [2:0]        dec_idx;
	// per-port byte lanes
	wire logic [7:0]        stat1_lane [PORTS];
	wire logic [7:0]        stat2_lane [PORTS];
	wire logic [RES_W-1:0]  res_word [PORTS];
	wire logic [RES_W-1:0]  res_sel_word;
	wire logic [7:0]        res_lane [RES_BYTES];
	// read side
	wire logic              hit_status;
	wire logic              hit_stat1;
	wire logic              hit_stat2;
	wire logic [7:0]        status_byte;
	wire logic [7:0]        stat1_byte;
	wire logic [7:0]        stat2_byte;
	wire logic [7:0]        res_byte;
	wire logic [7:0]        rd_next;
	wire logic [7:0]        ptr_readback;
	// write side
	wire logic              shared_we_next;
	wire logic              test_we_next;
	wire logic [3:0]        c1_we_next;
	wire logic [3:0]        c2_we_next;

	// selector decode
	poe_select_decode u_dec (
		.sel_in          (sel_reg),
		.port_in         (port_reg),
		.shared_ctrl_out (dec_shared),
		.test_out        (dec_test),
		.port_ctrl1_out  (dec_c1),
		.port_ctrl2_out  (dec_c2),
		.result_out      (dec_res),
		.result_idx_out  (dec_idx)
	);

	// fields of the select byte; D7 and D2 fall away here
	assign sel_next  = sel_byte_in[SEL_HI:SEL_LO];
	assign port_next = sel_byte_in[PORT_HI:PORT_LO];

	// latch pointer when the eighth bit has been taken
	always_ff @(posedge clk_in) begin
		if (!rstn_in) begin
			sel_reg  <= poe_select_pkg::PTR_RESET[SEL_HI:SEL_LO];
			port_reg <= poe_select_pkg::PTR_RESET[PORT_HI:PORT_LO];
		end else if (sel_stb_in) begin
			sel_reg  <= sel_next;
			port_reg <= port_next;
		end
	end

	// first stage of the fault synchroniser
	always_ff @(posedge clk_in) begin
		if (!rstn_in) begin
			fault_meta_reg <= 4'h0;
		end else begin
			fault_meta_reg <= port_fault_in;
		end
	end

	// second stage; only this flop reads the first
	always_ff @(posedge clk_in) begin
		if (!rstn_in) begin
			fault_reg <= 4'h0;
		end else begin
			fault_reg <= fault_meta_reg;
		end
	end

	// shared status: faults port4..1, revision, identity
	assign status_byte = {fault_reg, CHIP_REV, CHIP_ID};

	// two status lanes and one result word per port
	for (genvar p = 0; p < PORTS; p++) begin : g_port
		assign stat1_lane[p] = port_stat1_in[p*BYTE_W +: BYTE_W];
		assign stat2_lane[p] = port_stat2_in[p*BYTE_W +: BYTE_W];
		assign res_word[p]   = result_in[p*RES_W +: RES_W];
	end

	// result word of the chosen port, cut into bytes
	assign res_sel_word = res_word[port_reg];
	for (genvar b = 0; b < RES_BYTES; b++) begin : g_res
		assign res_lane[b] = res_sel_word[b*BYTE_W +: BYTE_W];
	end

	// read target decode
	assign hit_status =
		(sel_reg == poe_select_pkg::SEL_SHARED_STATUS);
	assign hit_stat1 =
		(sel_reg == poe_select_pkg::SEL_PORT_STAT1);
	assign hit_stat2 =
		(sel_reg == poe_select_pkg::SEL_PORT_STAT2);

	// byte of the chosen port for each read target
	assign stat1_byte = stat1_lane[port_reg];
	assign stat2_byte = stat2_lane[port_reg];
	assign res_byte   = res_lane[dec_idx];

	// read mux; write-only and unused codes read zero
	assign rd_next =
		hit_status ? status_byte :
		hit_stat1  ? stat1_byte :
		hit_stat2  ? stat2_byte :
		dec_res    ? res_byte :
		8'h00;

	// pointer readback with the spare bits held low
	assign ptr_readback = {1'b0, sel_reg, 1'b0, port_reg};

	// write strobes: shared ones once, per-port ones per lane
	assign shared_we_next = wr_stb_in & dec_shared;
	assign test_we_next   = wr_stb_in & dec_test;
	for (genvar p = 0; p < PORTS; p++) begin : g_we
		assign c1_we_next[p] = wr_stb_in & dec_c1[p];
		assign c2_we_next[p] = wr_stb_in & dec_c2[p];
	end

	// registered read byte
	always_ff @(posedge clk_in) begin
		if (!rstn_in) begin
			rd_data_out <= 8'h00;
		end else begin
			rd_data_out <= rd_next;
		end
	end

	// registered pointer readback
	always_ff @(posedge clk_in) begin
		if (!rstn_in) begin
			sel_byte_out <= 8'h00;
		end else begin
			sel_byte_out <= ptr_readback;
		end
	end

	// registered write strobes and data
	always_ff @(posedge clk_in) begin
		if (!rstn_in) begin
			shared_ctrl_we_out <= 1'b0;
			test_we_out        <= 1'b0;
			port_ctrl1_we_out  <= 4'h0;
			port_ctrl2_we_out  <= 4'h0;
			wr_data_out        <= 8'h00;
		end else begin
			shared_ctrl_we_out <= shared_we_next;
			test_we_out        <= test_we_next;
			port_ctrl1_we_out  <= c1_we_next;
			port_ctrl2_we_out  <= c2_we_next;
			wr_data_out        <= wr_data_in;
		end
	end
endmodule

// ===== sim/poe_select_sva.sv
`timescale 1ns/1ps
// port-level checks of the select decoder
module poe_select_sva (
	// watched ports
	input wire logic       clk_in,
	input wire logic       rstn_in,
	input wire logic       sel_stb_in,
	input wire logic [7:0] sel_byte_in,
	input wire logic       wr_stb_in,
	input wire logic [7:0] sel_byte_out,
	input wire logic       shared_ctrl_we_out,
	input wire logic       test_we_out,
	input wire logic [3:0] port_ctrl1_we_out,
	input wire logic [3:0] port_ctrl2_we_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (!rstn_in);
	// selector field as the write path sees it
	wire logic [3:0] s = sel_byte_out[6:3];
	AST_SEL: assert property (sel_stb_in ##1 !sel_stb_in |=>
		sel_byte_out == ($past(sel_byte_in, 2) & 8'h7B))
		else $error("select");
	AST_HOLD: assert property (!sel_stb_in ##1 !sel_stb_in |=>
		$stable(sel_byte_out)) else $error("select moved");
	AST_SHR: assert property (wr_stb_in && !$past(sel_stb_in) |=>
		shared_ctrl_we_out == ($past(s) == 4'h1)) else $error("shared");
	AST_TST: assert property (wr_stb_in && !$past(sel_stb_in) |=>
		test_we_out == ($past(s) == 4'hF)) else $error("test");
	AST_PC1: assert property (wr_stb_in && !$past(sel_stb_in) |=>
		port_ctrl1_we_out == ($past(s) == 4'h2 ?
		4'h1 << $past(sel_byte_out[1:0]) : 4'h0)) else $error("ctrl1");
	AST_PC2: assert property (wr_stb_in && !$past(sel_stb_in) |=>
		port_ctrl2_we_out == ($past(s) == 4'h3 ?
		4'h1 << $past(sel_byte_out[1:0]) : 4'h0)) else $error("ctrl2");
	AST_IDLE: assert property (!wr_stb_in |=>
		{shared_ctrl_we_out, test_we_out, port_ctrl1_we_out,
		port_ctrl2_we_out} == 10'h0) else $error("stray");
	AST_RSV: assert property (
		!sel_byte_out[7] && !sel_byte_out[2]) else $error("spare bits");
endmodule
bind poe_port_register_select_map poe_select_sva u_sva (.*);

// ===== sim/poe_host_model.sv
`timescale 1ns/1ps
// host side: sends select and data bytes
module poe_host_model (
	// serial clock and byte stream
	input  wire logic       clk_in,
	output logic            sel_out,
	output logic            wr_out,
	output logic [7:0]      byte_out
);
	// idle strobes low; bus inverted once released
	initial {sel_out, wr_out, byte_out} = 10'h0;
	task automatic put(input logic wr, input logic [7:0] b);
		@(negedge clk_in) {sel_out, wr_out, byte_out} = {!wr, wr, b};
		@(negedge clk_in) {sel_out, wr_out, byte_out} = {2'h0, ~b};
	endtask
endmodule

// ===== sim/tb.sv
`timescale 1ns/1ps
// table-driven bench of the select decoder
module tb;
	logic         clk_in = 1'b0, rstn_in = 1'b0, sel_stb_in, wr_stb_in;
	logic         shared_ctrl_we_out, test_we_out;
	logic [3:0]   port_fault_in = 4'h9, port_ctrl1_we_out, port_ctrl2_we_out;
	logic [7:0]   sel_byte_in, rd_data_out, sel_byte_out, wr_data_out;
	logic [31:0]  port_stat1_in = 32'h13121110, port_stat2_in = 32'h23222120;
	logic [255:0] result_in;
	int           err_count, num_checks, cyc;
	// select byte, read byte, then shared, test, ctrl1, ctrl2 strobes
	logic [27:0]  rows [16] = '{28'h0090000, 28'hA010000, 28'h2F23000,
		28'h3148000, 28'h3A51000, 28'h435A000, 28'h4843000, 28'h514C000,
		28'h5A55000, 28'h635E000, 28'h6847000, 28'h7000000, 28'h0800200,
		28'h1200040, 28'h1B00008, 28'h7800100};
	// device and host
	poe_port_register_select_map u_dut (.wr_data_in(sel_byte_in), .*);
	poe_host_model u_host (.clk_in(clk_in), .sel_out(sel_stb_in),
		.wr_out(wr_stb_in), .byte_out(sel_byte_in));
	// clock and hang guard
	initial forever #12.5 clk_in = ~clk_in;
	always @(posedge clk_in) if (++cyc > 2000) finish_test(1'b1);
	// compare and count
	task automatic check(input logic [11:0] got, input logic [11:0] exp);
		num_checks++;
		err_count += int'(got !== exp);
		if (got !== exp) $display("unexpected %0t %h %h", $time, got, exp);
	endtask
	// verdict
	task automatic finish_test(input logic hung);
		err_count += int'(hung);
		if (err_count == 0 && num_checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	// reset, table walk, reset in mid-run
	initial begin
		for (int k = 0; k < 32; k++) result_in[k*8 +: 8] = 8'h40 + 8'(k);
		repeat (2) @(negedge clk_in);
		rstn_in = 1'b1;
		foreach (rows[i]) begin
			u_host.put(1'b0, rows[i][27:20]);
			@(negedge clk_in);
			check(rd_data_out, rows[i][19:12]);
			check(sel_byte_out, rows[i][27:20] & 8'h7B);
			u_host.put(1'b1, 8'(i) ^ 8'h5A);
			check({shared_ctrl_we_out, test_we_out, port_ctrl1_we_out,
				port_ctrl2_we_out}, rows[i][11:0]);
			check(wr_data_out, 8'(i) ^ 8'h5A);
		end
		u_host.put(1'b0, 8'h00);
		port_fault_in = 4'h6;
		repeat (3) @(negedge clk_in);
		check(rd_data_out, 8'h60);
		rstn_in = 1'b0;
		@(negedge clk_in);
		check(sel_byte_out, 8'h00);
		check(rd_data_out, 8'h00);
		rstn_in = 1'b1;
		@(negedge clk_in);
		check(rd_data_out, 8'h00);
		check(sel_byte_out, 8'h00);
		repeat (2) @(negedge clk_in);
		check(rd_data_out, 8'h60);
		u_host.put(1'b0, 8'h20);
		@(negedge clk_in);
		check(rd_data_out, 8'h10);
		finish_test(1'b0);
	end
endmodule
